// File: pdrc_pkg.sv
// package for the power-down and reset control block
// assumes a single 10 MHz clock and synchronous active-high reset
package pdrc_pkg;
   localparam int unsigned   CLK_HZ          = 10000000;
   localparam int unsigned   WDT_DELAY_CLKS  = 512;
   localparam int unsigned   RST_HOLD_CYCLES = 2;
   localparam logic [1:0]    PWR_DOWN_BIT    = 2'd1;
   localparam logic [1:0]    PWR_IDLE_BIT    = 2'd0;
   localparam logic [15:0]   RESET_VECTOR    = 16'h0000;
   localparam logic [9:0]    WDT_LAST        = 10'(WDT_DELAY_CLKS - 1);
   localparam logic [1:0]    RST_LAST        = 2'(RST_HOLD_CYCLES - 1);
   localparam logic [7:0]    PORT_RESET      = 8'hff;

   typedef enum logic [1:0]
   {
      ST_C1 = 2'b00,
      ST_C2 = 2'b01,
      ST_C3 = 2'b10,
      ST_C4 = 2'b11
   } pdrc_state_t;

   typedef enum logic [1:0]
   {
      MODE_RUN  = 2'b00,
      MODE_IDLE = 2'b01,
      MODE_PD   = 2'b10
   } pdrc_mode_t;

   typedef struct packed
   {
      logic [1:0] enable;
      logic [1:0] level_mode;
      logic       global_irq_enable;
   } pdrc_irq_cfg_t;

   typedef struct packed
   {
      logic [7:0] p0;
      logic [7:0] p1;
      logic [7:0] p2;
      logic [7:0] p3;
   } pdrc_ports_t;

   function automatic logic int_wake(input pdrc_irq_cfg_t cfg, input logic [1:0] int_n);
      int_wake = cfg.global_irq_enable & |(cfg.enable & cfg.level_mode & ~int_n);
   endfunction : int_wake
endpackage : pdrc_pkg

// File: pdrc_phase.sv
// machine cycle phase generator
// assumes it is held while clocks are stopped
`timescale 1ns/1ns
module pdrc_phase
   import pdrc_pkg::*;
(
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         run_i,
   output pdrc_pkg::pdrc_state_t state_o
);
   pdrc_state_t state_r;
   pdrc_state_t state_nxt;

   always_comb
   begin
      case (state_r)
         ST_C1:   state_nxt = ST_C2;
         ST_C2:   state_nxt = ST_C3;
         ST_C3:   state_nxt = ST_C4;
         ST_C4:   state_nxt = ST_C1;
         default: state_nxt = ST_C1;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         state_r <= ST_C1;
      else if (run_i)
         state_r <= state_nxt;
   end

   assign state_o = state_r;
endmodule : pdrc_phase

// File: pdrc_top.sv
// power-down, idle and reset control of the core
// assumes pins synchronous to clk_i; core reads run/pc outputs
`timescale 1ns/1ns
module pdrc_top
   import pdrc_pkg::*;
(
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   input  wire logic                    reset_pin_i,
   input  wire logic [1:0]              ext_int_n_i,
   input  wire pdrc_pkg::pdrc_irq_cfg_t irq_cfg_i,
   input  wire logic                    power_control_register_wr_i,
   input  wire logic [7:0]              power_control_register_wdata_i,
   input  wire logic                    ext_prog_mem_i,
   input  wire pdrc_pkg::pdrc_ports_t   port_latch_i,
   input  wire logic [7:0]              addr_hi_i,
   input  wire logic                    wdt_timeout_i,
   input  wire logic                    wdt_restart_i,
   input  wire logic                    flag_clr_i,
   output pdrc_pkg::pdrc_state_t        state_o,
   output logic                         cpu_run_o,
   output logic                         clk_run_o,
   output logic                         core_reset_o,
   output logic                         skip_next_o,
   output logic                         wake_irq_o,
   output logic [1:0]                   wake_src_o,
   output logic [15:0]                  restart_pc_o,
   output logic                         ext_rst_flag_o,
   output logic                         wdt_rst_flag_o,
   output logic [1:0]                   mode_o,
   output logic                         ale_o,
   output logic                         prog_strobe_o,
   output pdrc_pkg::pdrc_ports_t        port_out_o,
   output logic                         port0_oe_o
);
   import pdrc_pkg::*;

   pdrc_mode_t  mode_r;
   pdrc_mode_t  mode_nxt;
   pdrc_state_t phase;
   logic [1:0]  rst_cnt_r;
   logic        rst_seen_r;
   logic [9:0]  wdt_cnt_r;
   logic        wdt_arm_r;
   logic        wdt_fire;
   logic        ext_fire;
   logic        wake;

   pdrc_phase pdrc_phase_i
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .run_i   (mode_r != MODE_PD),
      .state_o (phase)
   );

   assign wake = int_wake(irq_cfg_i, ext_int_n_i);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rst_cnt_r  <= 2'd0;
         rst_seen_r <= 1'b0;
      end
      else if (mode_r == MODE_PD)
      begin
         rst_seen_r <= reset_pin_i && !rst_seen_r;
         rst_cnt_r  <= reset_pin_i ? 2'(RST_HOLD_CYCLES) : 2'd0;
      end
      else if (phase == ST_C4)
      begin
         if (!reset_pin_i)
            rst_cnt_r <= 2'd0;
         else if (rst_cnt_r <= RST_LAST)
            rst_cnt_r <= rst_cnt_r + 2'd1;
         rst_seen_r <= reset_pin_i && (rst_cnt_r == RST_LAST);
      end
      else
         rst_seen_r <= 1'b0;
   end

   assign ext_fire = rst_seen_r;

   always_ff @(posedge clk_i)
   begin
      if (rst_i || wdt_restart_i)
      begin
         wdt_arm_r <= 1'b0;
         wdt_cnt_r <= 10'd0;
      end
      else if (mode_r != MODE_PD)
      begin
         if (wdt_timeout_i)
            wdt_arm_r <= 1'b1;
         if (wdt_arm_r)
            wdt_cnt_r <= (wdt_cnt_r == WDT_LAST) ? 10'd0 : wdt_cnt_r + 10'd1;
         if (wdt_arm_r && wdt_cnt_r == WDT_LAST)
            wdt_arm_r <= 1'b0;
      end
   end

   assign wdt_fire = wdt_arm_r && (wdt_cnt_r == WDT_LAST) && (mode_r != MODE_PD);

   always_comb
   begin
      mode_nxt = mode_r;
      case (mode_r)
         MODE_RUN:
         begin
            if (power_control_register_wr_i && power_control_register_wdata_i[PWR_DOWN_BIT])
               mode_nxt = MODE_PD;
            else if (power_control_register_wr_i && power_control_register_wdata_i[PWR_IDLE_BIT])
               mode_nxt = MODE_IDLE;
         end
         MODE_IDLE:
         begin
            if (wake)
               mode_nxt = MODE_RUN;
         end
         MODE_PD:
         begin
            if (wake)
               mode_nxt = MODE_RUN;
         end
         default:
            mode_nxt = MODE_RUN;
      endcase
      if (ext_fire || wdt_fire)
         mode_nxt = MODE_RUN;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         mode_r <= MODE_RUN;
      else
         mode_r <= mode_nxt;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         core_reset_o   <= 1'b1;
         ext_rst_flag_o <= 1'b0;
         wdt_rst_flag_o <= 1'b0;
         skip_next_o    <= 1'b0;
         restart_pc_o   <= RESET_VECTOR;
      end
      else
      begin
         core_reset_o   <= ext_fire || wdt_fire;
         ext_rst_flag_o <= ext_fire || (ext_rst_flag_o && !flag_clr_i);
         wdt_rst_flag_o <= wdt_fire || (wdt_rst_flag_o && !flag_clr_i);
         skip_next_o    <= (ext_fire || wdt_fire) && (mode_r == MODE_IDLE);
         restart_pc_o   <= RESET_VECTOR;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wake_irq_o <= 1'b0;
         wake_src_o <= 2'd0;
      end
      else
      begin
         wake_irq_o <= (mode_r == MODE_PD) && wake && !ext_fire;
         wake_src_o <= irq_cfg_i.enable & irq_cfg_i.level_mode & ~ext_int_n_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cpu_run_o <= 1'b1;
         clk_run_o <= 1'b1;
         mode_o    <= MODE_RUN;
         state_o   <= ST_C1;
      end
      else
      begin
         cpu_run_o <= (mode_r == MODE_RUN);
         clk_run_o <= (mode_r != MODE_PD);
         mode_o    <= mode_r;
         state_o   <= phase;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ale_o         <= 1'b1;
         prog_strobe_o <= 1'b1;
         port_out_o    <= {4{PORT_RESET}};
         port0_oe_o    <= 1'b1;
      end
      else
      begin
         ale_o         <= (mode_r != MODE_PD);
         prog_strobe_o <= (mode_r != MODE_PD);
         port_out_o    <= port_latch_i;
         port0_oe_o    <= !(ext_prog_mem_i && mode_r != MODE_RUN);
         if (mode_r == MODE_IDLE && ext_prog_mem_i)
            port_out_o.p2 <= addr_hi_i;
      end
   end
endmodule : pdrc_top

// File: pdrc_assertions.sv
// checker on the ports of pdrc_top
// assumes bind from the bench top file
`timescale 1ns/1ns
module pdrc_assertions
   import pdrc_pkg::*;
(
   input wire logic                  clk_i,
   input wire logic                  rst_i,
   input wire logic [1:0]            ext_int_n_i,
   input wire pdrc_pkg::pdrc_irq_cfg_t irq_cfg_i,
   input wire logic                  power_control_register_wr_i,
   input wire logic [7:0]            power_control_register_wdata_i,
   input wire logic                  ext_prog_mem_i,
   input wire pdrc_pkg::pdrc_ports_t port_latch_i,
   input wire pdrc_pkg::pdrc_state_t state_o,
   input wire logic                  clk_run_o,
   input wire logic                  core_reset_o,
   input wire logic                  wake_irq_o,
   input wire logic [15:0]           restart_pc_o,
   input wire logic [1:0]            mode_o,
   input wire logic                  ale_o,
   input wire logic                  prog_strobe_o,
   input wire pdrc_pkg::pdrc_ports_t port_out_o,
   input wire logic                  port0_oe_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire pd = mode_o == 2'b10;
   wire wk = irq_cfg_i.global_irq_enable & |(irq_cfg_i.enable & irq_cfg_i.level_mode & ~ext_int_n_i);
   a_phase_step: assert property ($changed(state_o) |-> state_o == 2'($past(state_o) + 1))
      else $error("phase skipped");
   a_pd_entry: assert property (power_control_register_wr_i && power_control_register_wdata_i[1] && mode_o == 2'b00
      && !($past(power_control_register_wr_i) && ($past(power_control_register_wdata_i) & 8'h03) != 8'h00) |-> ##2 pd)
      else $error("no power-down");
   a_pd_halt: assert property (pd |-> !ale_o && !prog_strobe_o && !clk_run_o)
      else $error("pd pins wrong");
   a_pd_ports: assert property (pd && $stable(port_latch_i) |-> port_out_o == port_latch_i)
      else $error("pd port lost");
   a_idle_strobes: assert property (mode_o == 2'b01 |-> ale_o && prog_strobe_o)
      else $error("idle strobes");
   a_port0_float: assert property (mode_o != 2'b00 && $past(ext_prog_mem_i) |-> !port0_oe_o)
      else $error("port0 driven");
   a_reset_vector: assert property (restart_pc_o == 16'h0000)
      else $error("restart pc");
   a_wake_irq: assert property ($rose(pd && wk) |-> ##[1:2] wake_irq_o)
      else $error("no wake");
   a_reset_pulse: assert property (core_reset_o |=> !core_reset_o)
      else $error("reset too long");
endmodule : pdrc_assertions

// File: pdrc_pins.sv
// far-side model: reset source and interrupt pins
// assumes commands from the bench at the falling edge
`timescale 1ns/1ns
module pdrc_pins
(
   input  wire logic       clk_i,
   input  wire logic [4:0] rst_len_i,
   input  wire logic [1:0] wake_i,
   input  wire logic       ack_i,
   output logic            reset_pin_o,
   output logic [1:0]      ext_int_n_o = 2'h3
);
   logic [4:0] cnt_r = 5'h00;
   always_ff @(posedge clk_i)
   begin
      cnt_r <= (rst_len_i != 5'h00) ? rst_len_i : cnt_r - 5'(cnt_r != 5'h00);
   end
   assign reset_pin_o = cnt_r != 5'h00;
   always_ff @(posedge clk_i)
   begin
      ext_int_n_o <= ack_i ? 2'h3 : ext_int_n_o & ~wake_i;
   end
endmodule : pdrc_pins

// File: tb_pdrc_top.sv
// bench for power-down and reset control
// assumes pdrc_top, pin model and checker compiled first
`timescale 1ns/1ns
module tb_pdrc_top;
   import pdrc_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, power_control_register_wr_i = 1'b0, wdt_timeout_i = 1'b0, wdt_restart_i = 1'b0;
   logic flag_clr_i = 1'b0, ext_prog_mem_i = 1'b1, reset_pin_i, wake_irq_o;
   logic cpu_run_o, clk_run_o, core_reset_o, skip_next_o, ext_rst_flag_o, wdt_rst_flag_o;
   logic ale_o, prog_strobe_o, port0_oe_o;
   logic [7:0] power_control_register_wdata_i = 8'h00, addr_hi_i = 8'h5a;
   logic [4:0] rst_len = 5'h00;
   logic [1:0] wake = 2'h0, s, ext_int_n_i, mode_o, wake_src_o;
   logic [15:0] restart_pc_o;
   pdrc_irq_cfg_t irq_cfg_i = 5'h00;
   pdrc_ports_t port_latch_i = 32'h0f96a53c, port_out_o;
   pdrc_state_t state_o;
   int mismatches = 0, checks = 0, n;
   pdrc_top pdrc_top_i (.*);
   pdrc_pins pdrc_pins_i (.clk_i(clk_i), .rst_len_i(rst_len), .wake_i(wake),
      .ack_i(wake_irq_o), .reset_pin_o(reset_pin_i), .ext_int_n_o(ext_int_n_i));
   initial
   begin
      forever #50 clk_i = ~clk_i;
   end
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic step(input int k);
      repeat (k) @(negedge clk_i);
   endtask : step
   task automatic tap(ref logic sig);
      @(negedge clk_i);
      sig = 1'b1;
      @(negedge clk_i);
      sig = 1'b0;
   endtask : tap
   task automatic power_control_register(input logic [7:0] d);
      power_control_register_wdata_i = d;
      tap(power_control_register_wr_i);
      step(2);
   endtask : power_control_register
   task automatic wait_hi(ref logic sig, input int lim);
      for (n = 0; sig !== 1'b1 && n < lim; n++)
         step(1);
   endtask : wait_hi
   task automatic pin_rst(input logic [4:0] len);
      step(1);
      rst_len = len;
      step(1);
      rst_len = 5'h00;
   endtask : pin_rst
   initial
   begin
      #500000;
      mismatches++;
      stop_test();
   end
   initial
   begin
      step(12);
      rst_i = 1'b0;
      step(2);
      chk({ext_rst_flag_o, wdt_rst_flag_o}, 2'h0);
      for (int i = 0; i < 4; i++)
      begin
         s = state_o;
         step(1);
         chk(state_o, 2'(s + 2'h1));
      end
      power_control_register(8'h02);
      chk({mode_o, ale_o, prog_strobe_o, clk_run_o, port0_oe_o}, 6'h20);
      chk(port_out_o, 32'h0f96a53c);
      chk(cpu_run_o, 1'b0);
      s = state_o;
      tap(wdt_timeout_i);
      power_control_register(8'h01);
      step(600);
      chk({state_o, mode_o, wdt_rst_flag_o}, {s, 3'h4});
      pin_rst(5'h0a);
      wait_hi(core_reset_o, 20);
      chk(skip_next_o, 1'b0);
      step(2);
      chk({n < 20, ext_rst_flag_o, mode_o, restart_pc_o}, 20'hc0000);
      $display("test power-down done");
      tap(flag_clr_i);
      step(8);
      pin_rst(5'h01);
      wait_hi(core_reset_o, 12);
      chk(n, 12);
      power_control_register(8'h01);
      chk({mode_o, ale_o, prog_strobe_o, port0_oe_o}, 5'h0e);
      chk(port_out_o.p2, addr_hi_i);
      chk({cpu_run_o, clk_run_o}, 2'h1);
      ext_prog_mem_i = 1'b0;
      step(2);
      chk({port0_oe_o, port_out_o.p0, port_out_o.p2}, 17'h10fa5);
      ext_prog_mem_i = 1'b1;
      pin_rst(5'h0a);
      wait_hi(core_reset_o, 20);
      chk(skip_next_o, 1'b1);
      $display("test idle done");
      step(3);
      tap(flag_clr_i);
      power_control_register(8'h02);
      irq_cfg_i = 5'h0a;
      wake = 2'h1;
      step(1);
      wake = 2'h0;
      step(10);
      chk(mode_o, 2'h2);
      irq_cfg_i = 5'h0b;
      wait_hi(wake_irq_o, 10);
      chk({n < 10, wake_src_o}, 3'h5);
      step(3);
      chk({mode_o, cpu_run_o}, 3'h1);
      irq_cfg_i = 5'h00;
      $display("test wake done");
      tap(wdt_timeout_i);
      step(100);
      tap(wdt_restart_i);
      wait_hi(core_reset_o, 600);
      chk(n, 600);
      tap(wdt_timeout_i);
      wait_hi(core_reset_o, 600);
      step(2);
      chk({n > 507, n < 514, wdt_rst_flag_o, ext_rst_flag_o}, 4'he);
      $display("test watchdog done");
      stop_test();
   end
endmodule : tb_pdrc_top
bind pdrc_top pdrc_assertions pdrc_assertions_i (.*);
